/* File: verilog/brq_pkg.sv */
package brq_pkg;
	// clock rate
	localparam int CLK_MHZ = 100;
	// stop and release deadlines after the reset line falls, in microseconds
	localparam int STROBE_STOP_US = 5;
	localparam int MASTER_REL_US = 20;
	localparam int SLAVE_REL_US = 30;
	localparam int GRANT_STOP_US = 5;
	// least low time for a reset that this board drives, in milliseconds
	localparam int RST_HOLD_MS = 200;
	// latest assertion of the failure line after reset falls
	localparam int FAIL_LATE_MS = 50;
	// synchroniser depth: three flops, change once last two agree
	localparam int SYNC_LAT = 3;
	// cycle counts; deadlines are longest times, so subtract the
	// synchroniser, the level flop and the output flop as margin
	localparam int SYNC_MARGIN = SYNC_LAT + 2;
	localparam int STROBE_STOP_CYC = STROBE_STOP_US * CLK_MHZ - SYNC_MARGIN;
	localparam int MASTER_REL_CYC = MASTER_REL_US * CLK_MHZ - SYNC_MARGIN;
	localparam int SLAVE_REL_CYC = SLAVE_REL_US * CLK_MHZ - SYNC_MARGIN;
	localparam int GRANT_STOP_CYC = GRANT_STOP_US * CLK_MHZ - SYNC_MARGIN;
	localparam int RST_HOLD_CYC = RST_HOLD_MS * 1000 * CLK_MHZ;
	// protocol least strobe low time, cycles
	localparam int STROBE_MIN_CYC = 4;
	localparam int CNT_W = 12;
	localparam int HOLD_W = 25;
	localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
	localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
	localparam logic [HOLD_W-1:0] HOLD_ZERO = 25'h000_0000;
	localparam logic [HOLD_W-1:0] HOLD_ONE = 25'h000_0001;
endpackage

/* File: verilog/brq_quiesce.sv */
`timescale 1ns/100ps
// How it works
// [RULE1] strobes already low at reset stay low until their least low time
// [RULE2] no new strobe falling edge once reset has been low 5 us
// [RULE3] master drivers released once reset has been low 20 us
// [RULE4] slave data, acknowledge and error drivers released by 30 us
// [RULE5] interrupt, timer error, bus busy and grant lows released by 30 us
// [RULE6] arbiter starts no new grant falling edge after 5 us of reset
// [RULE7] after deadlines, drivers stay put until reset rises or power fails
// [RULE8] any reset this board drives is held low at least 200 ms
// [RULE9] failure line asserted during power up until self-test is done
// [RULE10] failure bit asserts the failure line within 50 ms of reset
// [RULE11] board may assert the failure line anytime on a detected fault
// [RULE12] local processor clears the failure bit after its self-test passes
// [RULE13] external master may write the failure bit to release the line
// [RULE14] front-panel indicator follows the failure bit
// [RULE15] the reserved backplane line is never driven
// [RULE16] reset input synchronised; counter times deadlines with margin
// [RULE17] failure bit set by power-on and reset, changed only by write; a detected fault also sets it
module brq_quiesce
	import brq_pkg::*;
#(
	parameter int HOLD_CYC = RST_HOLD_CYC
) (
	// clock and power-on reset
	input wire logic clk,
	input wire logic nrst,
	// backplane reset line, open collector
	input wire logic sysreset_n_in,
	output logic sysreset_n_out,
	output logic sysreset_n_oe,
	// supply monitor, high while +5 V in range
	input wire logic pwr_ok,
	// local request to pull reset, a pulse (push button)
	input wire logic rst_req,
	// board drive requests from the bus engines
	input wire logic strobe_req,
	input wire logic mst_req,
	input wire logic slv_req,
	input wire logic irq_req,
	input wire logic timer_req,
	input wire logic busy_req,
	input wire logic grant_req,
	// gated driver enables
	output logic strobe_oe,
	output logic mst_oe,
	output logic slv_oe,
	output logic irq_oe,
	output logic timer_oe,
	output logic busy_oe,
	output logic grant_oe,
	// failure bit write port (local or bus) and fault detect
	input wire logic fail_wr,
	input wire logic fail_wdata,
	input wire logic fault,
	// failure line, open collector, and indicator
	output logic sysfail_n_out,
	output logic sysfail_n_oe,
	output logic fail_led,
	// reserved line, never driven
	output logic reserved_oe
);
	logic [2:0] rs_q;
	logic rst_low_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [CNT_W-1:0] slow_q;
	logic fail_q;
	logic [HOLD_W-1:0] hold_q;
	logic drv_q;
	logic strobe_q;
	logic grant_q;
	logic [CNT_W-1:0] slow_d;

	// deadline compare, shared by every stop and release point
	function automatic logic past_limit(input logic [CNT_W-1:0] cnt,
		input int lim);
		return cnt >= CNT_W'(lim);
	endfunction

	// triple flop; level changes only when last two stages agree
	wire rs_agree = rs_q[1] == rs_q[2];
	wire rst_low_d = rs_agree ? ~rs_q[2] : rst_low_q; // RULE16
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rs_q <= 3'h7;
			rst_low_q <= 1'b0;
		end else begin
			rs_q <= {rs_q[1:0], sysreset_n_in};
			rst_low_q <= rst_low_d;
		end
	end

	// deadline counter saturates past the last deadline
	wire cnt_sat = past_limit(cnt_q, SLAVE_REL_CYC);
	assign cnt_d = !rst_low_q ? CNT_ZERO : (cnt_sat ? cnt_q : cnt_q + CNT_ONE);
	wire quiet_in = rst_low_q && pwr_ok;
	wire strobe_stop = quiet_in && past_limit(cnt_q, STROBE_STOP_CYC); // RULE2
	wire grant_stop = quiet_in && past_limit(cnt_q, GRANT_STOP_CYC); // RULE6
	wire mst_rel = quiet_in && past_limit(cnt_q, MASTER_REL_CYC); // RULE3
	wire slv_rel = quiet_in && past_limit(cnt_q, SLAVE_REL_CYC); // RULE4 RULE5

	// a strobe low before the stop time may finish its least low time
	wire strobe_min_met = slow_q >= CNT_W'(STROBE_MIN_CYC);
	assign slow_d = !strobe_q ? CNT_ZERO
		: (strobe_min_met ? slow_q : slow_q + CNT_ONE);
	wire strobe_keep = strobe_q && (!strobe_min_met || strobe_req); // RULE1
	// hold only while reset is seen; the engine owns normal strobe widths
	wire strobe_hold = quiet_in && strobe_q && !strobe_min_met; // RULE1
	wire strobe_d = mst_rel ? 1'b0
		: strobe_hold ? 1'b1
		: strobe_stop ? (strobe_keep && strobe_req)
		: strobe_req; // RULE2
	// grant may stay low but no new fall after the stop time
	wire grant_d = slv_rel ? 1'b0
		: grant_stop ? (grant_q && grant_req) : grant_req; // RULE6 RULE5

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= CNT_ZERO;
			slow_q <= CNT_ZERO;
			strobe_q <= 1'b0;
			grant_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			slow_q <= slow_d;
			strobe_q <= strobe_d;
			grant_q <= grant_d;
		end
	end

	// once released, outputs hold until reset rises, pwr loss reopens
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			strobe_oe <= 1'b0;
			mst_oe <= 1'b0;
			slv_oe <= 1'b0;
			irq_oe <= 1'b0;
			timer_oe <= 1'b0;
			busy_oe <= 1'b0;
			grant_oe <= 1'b0;
		end else begin
			strobe_oe <= strobe_d; // RULE7
			mst_oe <= mst_req && !mst_rel; // RULE3
			slv_oe <= slv_req && !slv_rel; // RULE4
			irq_oe <= irq_req && !slv_rel; // RULE5
			timer_oe <= timer_req && !slv_rel; // RULE5
			busy_oe <= busy_req && !slv_rel; // RULE5
			grant_oe <= grant_d; // RULE6
		end
	end

	// local reset pull, held for the full least low time
	wire hold_run = hold_q != HOLD_ZERO;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hold_q <= HOLD_ZERO;
			drv_q <= 1'b0;
		end else begin
			if (rst_req && !hold_run)
				hold_q <= HOLD_W'(HOLD_CYC); // RULE8
			else if (hold_run)
				hold_q <= hold_q - HOLD_ONE;
			drv_q <= (rst_req && !hold_run) || (hold_q > HOLD_ONE); // RULE8
		end
	end
	assign sysreset_n_oe = drv_q;

	// failure bit: set by power-on and reset, cleared only by a write
	// set wins over a clearing write in the same cycle
	wire fail_set = rst_low_d || fault; // RULE10 RULE11 RULE17
	wire fail_next = fail_set || (fail_wr ? fail_wdata : fail_q);
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fail_q <= 1'b1; // RULE9 RULE17
			fail_led <= 1'b1;
			sysfail_n_oe <= 1'b1;
		end else begin
			if (fail_set)
				fail_q <= 1'b1;
			else if (fail_wr)
				fail_q <= fail_wdata; // RULE12 RULE13
			fail_led <= fail_next; // RULE14
			sysfail_n_oe <= fail_next;
		end
	end

	// pin levels of the open-collector lines, from flops as well
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sysreset_n_out <= 1'b0;
			sysfail_n_out <= 1'b0;
			reserved_oe <= 1'b0;
		end else begin
			sysreset_n_out <= 1'b0;
			sysfail_n_out <= 1'b0;
			reserved_oe <= 1'b0; // RULE15
		end
	end

	// quiesce checks
	strobe_stop_a: assert property (@(posedge clk) disable iff (!nrst) // RULE2
		strobe_stop && !strobe_q |=> !strobe_oe)
		else $error("new strobe after stop time");

	strobe_min_a: assert property (@(posedge clk) disable iff (!nrst) // RULE1
		strobe_hold && !mst_rel |=> strobe_oe)
		else $error("strobe cut short");

	master_rel_a: assert property (@(posedge clk) disable iff (!nrst) // RULE3
		mst_rel |=> !mst_oe && !strobe_oe)
		else $error("master drivers not released");

	slave_rel_a: assert property (@(posedge clk) disable iff (!nrst) // RULE4
		slv_rel |=> !slv_oe && !irq_oe && !timer_oe)
		else $error("slave drivers not released");

	bus_rel_a: assert property (@(posedge clk) disable iff (!nrst) // RULE5
		slv_rel |=> !busy_oe && !grant_oe)
		else $error("busy or grant not released");

	grant_stop_a: assert property (@(posedge clk) disable iff (!nrst) // RULE6
		grant_stop && !grant_q |=> !grant_oe)
		else $error("new grant after stop time");

	grant_keep_a: assert property (@(posedge clk) disable iff (!nrst) // RULE6
		grant_stop && !slv_rel && grant_q && grant_req |=> grant_oe)
		else $error("held grant dropped before release");

	power_lost_a: assert property (@(posedge clk) disable iff (!nrst) // RULE7
		!pwr_ok |=> mst_oe == $past(mst_req) && slv_oe == $past(slv_req))
		else $error("drivers gated with supply out of range");

	free_run_a: assert property (@(posedge clk) disable iff (!nrst) // RULE7
		!rst_low_q |=> busy_oe == $past(busy_req)
			&& strobe_oe == $past(strobe_req))
		else $error("drivers gated outside reset");

	// synchroniser and counter checks
	sync_agree_a: assert property (@(posedge clk) disable iff (!nrst) // RULE16
		rs_agree |=> rst_low_q == !$past(rs_q[2]))
		else $error("reset level not taken on agreement");

	cnt_idle_a: assert property (@(posedge clk) disable iff (!nrst) // RULE16
		!rst_low_q |=> cnt_q == CNT_ZERO)
		else $error("deadline counter runs outside reset");

	counter_top_a: assert property (@(posedge clk) disable iff (!nrst) // RULE16
		cnt_q <= CNT_W'(SLAVE_REL_CYC))
		else $error("deadline counter past saturation");

	// failure bit checks
	fail_assert_a: assert property (@(posedge clk) disable iff (!nrst) // RULE10
		rst_low_q |=> sysfail_n_oe && fail_led)
		else $error("failure line not asserted in reset");

	fault_flag_a: assert property (@(posedge clk) disable iff (!nrst) // RULE11
		fault |=> sysfail_n_oe)
		else $error("fault did not assert failure line");

	fail_write_a: assert property (@(posedge clk) disable iff (!nrst) // RULE12
		fail_wr && !fail_set |=> fail_q == $past(fail_wdata))
		else $error("failure bit write lost");

	fail_release_a: assert property (@(posedge clk) disable iff (!nrst) // RULE13
		fail_wr && !fail_wdata && !fail_set |=> !sysfail_n_oe)
		else $error("failure line not released by write");

	led_follow_a: assert property (@(posedge clk) disable iff (!nrst) // RULE14
		fail_led == fail_q)
		else $error("indicator differs from failure bit");

	fail_reset_a: assert property (@(posedge clk) disable iff (!nrst) // RULE17
		rst_low_d |=> fail_q)
		else $error("reset did not set failure bit");

	fail_clear_a: assert property (@(posedge clk) disable iff (!nrst) // RULE17
		!fail_set && !fail_wr |=> fail_q == $past(fail_q))
		else $error("failure bit changed without write");

	// reset pull and reserved line checks
	reset_hold_a: assert property (@(posedge clk) disable iff (!nrst) // RULE8
		$rose(drv_q) |=> drv_q [*8])
		else $error("reset pull dropped early");

	pull_start_a: assert property (@(posedge clk) disable iff (!nrst) // RULE8
		rst_req && !hold_run |=> drv_q)
		else $error("reset pull not started");

	pull_run_a: assert property (@(posedge clk) disable iff (!nrst) // RULE8
		hold_run |-> drv_q)
		else $error("reset pull off while timer runs");

	reserved_a: assert property (@(posedge clk) disable iff (!nrst) // RULE15
		!reserved_oe)
		else $error("reserved line driven");

	// scenario covers
	rst_seen_c: cover property (@(posedge clk) disable iff (!nrst) slv_rel);
	fail_clr_c: cover property (@(posedge clk) disable iff (!nrst)
		fail_wr && !fail_wdata && !fail_set);
	pull_c: cover property (@(posedge clk) disable iff (!nrst) $fell(drv_q));
	strobe_hold_c: cover property (@(posedge clk) disable iff (!nrst)
		strobe_hold);
	power_lost_c: cover property (@(posedge clk) disable iff (!nrst)
		rst_low_q && !pwr_ok);
endmodule

/* File: testbench/brq_power_mon.sv */
`timescale 1ns/100ps
// power monitor on the shared open-collector reset line; the line has a
// pull-up, so it reads high unless this model or the board pulls it
module brq_power_mon #(
	// shortened stand-in for the 200 ms least low time
	parameter int HOLD = 3100
) (
	// clock and pull request
	input wire logic clk,
	input wire logic go,
	input wire logic dut_oe,
	// shared reset line level
	output logic line_n
);
	int cnt = 0;
	// changes on the falling edge so the board samples a settled level
	always @(negedge clk) begin
		if (go)
			cnt <= HOLD;
		else if (cnt > 0)
			cnt <= cnt - 1;
	end
	assign line_n = !(cnt > 0 || dut_oe);
endmodule

/* File: testbench/tb_brq_quiesce.sv */
`timescale 1ns/100ps
module tb_brq_quiesce;
	import brq_pkg::*;
	logic clk = 0;
	logic nrst = 0;
	logic pwr_ok = 1;
	logic rst_req = 0;
	logic go = 0;
	logic fail_wr = 0;
	logic fail_wdata = 0;
	logic fault = 0;
	logic [6:0] req = 7'h00;
	wire rst_line_n, sr_oe, sf_oe, led, res_oe, sro, sfo;
	wire [6:0] oe;
	logic [10:0] q[$];
	logic [10:0] e;
	int errors = 0;
	int n_tests = 0;
	initial forever #5 clk = ~clk;
	brq_power_mon #(.HOLD(3100)) pm (.clk(clk), .go(go), .dut_oe(sr_oe),
		.line_n(rst_line_n));
	brq_quiesce #(.HOLD_CYC(50)) dut (.clk(clk), .nrst(nrst),
		.sysreset_n_in(rst_line_n), .sysreset_n_out(sro), .sysreset_n_oe(sr_oe),
		.pwr_ok(pwr_ok), .rst_req(rst_req), .strobe_req(req[6]),
		.mst_req(req[5]), .slv_req(req[4]), .irq_req(req[3]),
		.timer_req(req[2]), .busy_req(req[1]), .grant_req(req[0]),
		.strobe_oe(oe[6]), .mst_oe(oe[5]), .slv_oe(oe[4]), .irq_oe(oe[3]),
		.timer_oe(oe[2]), .busy_oe(oe[1]), .grant_oe(oe[0]),
		.fail_wr(fail_wr), .fail_wdata(fail_wdata), .fault(fault),
		.sysfail_n_out(sfo), .sysfail_n_oe(sf_oe), .fail_led(led),
		.reserved_oe(res_oe));
	// expectations are pushed just after a falling edge, compared at the next
	always @(negedge clk) begin
		if (q.size() > 0) begin
			e = q.pop_front();
			n_tests++;
			if ({oe, sf_oe, led, sr_oe, res_oe} !== e) begin
				errors++;
				$display("MISMATCH outputs exp %b seen %b", e,
					{oe, sf_oe, led, sr_oe, res_oe});
			end
			if (sro !== 1'b0 || sfo !== 1'b0) begin
				errors++;
				$display("MISMATCH pull levels exp 00 seen %b%b", sro, sfo);
			end
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic chk(input logic [10:0] v);
		#1 q.push_back(v);
		@(negedge clk);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#100000;
		errors++;
		end_of_test();
	end
	initial begin
		void'($urandom(32'hb6871408));
		cyc(5);
		nrst = 1;
		chk({7'h00, 4'hc});
		for (int i = 0; i < 16; i++) begin
			req = 7'($urandom);
			chk({req, 4'hc});
		end
		fail_wr = 1;
		chk({req, 4'h0});
		fail_wr = 0;
		fault = 1;
		chk({req, 4'hc});
		fault = 0;
		fail_wr = 1;
		chk({req, 4'h0});
		fail_wdata = 1;
		chk({req, 4'hc});
		fail_wr = 0;
		$display("test fail_bit done");
		// line falls one edge after the pull request
		req = 7'h3f;
		go <= 1;
		cyc(1);
		go <= 0;
		cyc(4);
		req = 7'h7f;
		cyc(1);
		req = 7'h3e;
		chk({7'h7e, 4'hc});
		cyc(496);
		req = 7'h7f;
		chk({7'h3e, 4'hc});
		cyc(1497);
		chk({7'h1e, 4'hc});
		cyc(999);
		chk({7'h00, 4'hc});
		for (int i = 0; i < 20; i++) begin
			req = 7'($urandom);
			chk({7'h00, 4'hc});
		end
		// a supply outside its range lifts the hold-off
		pwr_ok = 0;
		req = 7'h7f;
		chk({7'h7f, 4'hc});
		pwr_ok = 1;
		req = 7'h00;
		cyc(100);
		chk({7'h00, 4'hc});
		$display("test reset_quiesce done");
		rst_req = 1;
		chk({7'h00, 4'he});
		rst_req = 0;
		cyc(48);
		chk({7'h00, 4'he});
		chk({7'h00, 4'hc});
		$display("test local_reset done");
		end_of_test();
	end
endmodule
